/* tprc_consts.svh */
`ifndef TPRC_CONSTS_SVH
`define TPRC_CONSTS_SVH
// register word offsets (byte addresses, one 32-bit word each)
`define TPRC_OFS_CTRL 8'h00
`define TPRC_OFS_CLEAR 8'h04
`define TPRC_OFS_RAMP_EN 8'h08
`define TPRC_OFS_STICKY 8'h0C
`define TPRC_OFS_SEL 8'h10
`define TPRC_OFS_CREST_CFG 8'h14
`define TPRC_OFS_MEAN_CFG 8'h18
`define TPRC_OFS_STATUS 8'h1C
`define TPRC_OFS_MEAN_POWER 8'h20
`define TPRC_OFS_TRIP_POWER 8'h24
`define TPRC_OFS_RATIO 8'h28
// clear codes
`define TPRC_CLR_MEAN 2'h1
`define TPRC_CLR_CREST 2'h2
`define TPRC_CLR_BOTH 2'h3
// ramp-down source bit positions
`define TPRC_SRC_PROT 7
`define TPRC_SRC_DFR0 0
// attenuation target in dB and per-cycle step
`define TPRC_ATTEN_MAX_DB 8'h28
`define TPRC_ATTEN_STEP 8'h01
// window length base: 2^(len+5) samples
`define TPRC_WINDOW_BASE 5
// sticky reset value: all manual clear (sticky default)
`define TPRC_STICKY_RST 3'h7
`endif

/* tprc_pkg.sv */
// Purpose: types for the transmit power trip and ramp-down block
// Assumes: tprc_consts.svh holds the numbers
// Notes: none
package tprc_pkg;
  typedef struct packed {
    logic [15:0] crest_level_limit;
    logic [7:0] crest_count_limit;
    logic [3:0] crest_window_len;
    logic [15:0] mean_level_limit;
    logic [3:0] mean_window_len;
    logic crest_en;
    logic mean_en;
    logic ratio_en;
  } tprc_meas_cfg_t;
  typedef struct packed {
    logic crest_trip;
    logic mean_trip;
    logic [15:0] mean_power;
    logic [15:0] peak_power;
    logic mean_done;
  } tprc_meas_out_t;
  typedef struct packed {
    logic [7:0] win_cnt_unused;
  } tprc_dummy_t;
endpackage : tprc_pkg

/* tprc_crest_mon.sv */
// Purpose: peak sample counting against a limit per window
// Assumes: one sample per clock
// Notes: trip is a level for the rest of the window
`include "tprc_consts.svh"
module tprc_crest_mon (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic [15:0] sample_power,
  input wire logic [15:0] crest_level_limit,
  input wire logic [7:0] crest_count_limit,
  input wire logic [3:0] crest_window_len,
  output logic trip,
  output logic [15:0] peak_power
);
  typedef struct packed {
    logic [20:0] win;
    logic [8:0] count;
    logic trip;
    logic [15:0] peak;
    logic [15:0] last;
  } tprc_crest_st_t;
  tprc_crest_st_t st_reg, st_next;
  logic [20:0] win_end;
  assign win_end = 21'((21'h1 << (5'(crest_window_len) + 5'(`TPRC_WINDOW_BASE))) - 21'h1);
  always_comb begin
    st_next = st_reg;
    if (!enable) begin
      st_next = '0;
    end else begin
      if (sample_power > st_reg.peak) st_next.peak = sample_power;
      if (sample_power > crest_level_limit && st_reg.count != 9'h1FF)
        st_next.count = st_reg.count + 9'h001;
      st_next.trip = st_next.count > {1'b0, crest_count_limit};
      if (st_reg.win == win_end) begin
        st_next.win = '0;
        st_next.count = '0;
        // completed window peak stays visible for the ratio
        st_next.last = st_next.peak;
        st_next.peak = '0;
      end else begin
        st_next.win = st_reg.win + 21'h000001;
      end
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) st_reg <= '0;
    else st_reg <= st_next;
  end
  assign trip = st_reg.trip;
  assign peak_power = st_reg.last;
endmodule : tprc_crest_mon

/* tprc_mean_mon.sv */
// Purpose: windowed mean power and threshold compare
// Assumes: one sample per clock
// Notes: result updates at each window end
`include "tprc_consts.svh"
module tprc_mean_mon (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic [15:0] sample_power,
  input wire logic [15:0] mean_level_limit,
  input wire logic [3:0] mean_window_len,
  output logic trip,
  output logic done,
  output logic [15:0] mean_power
);
  typedef struct packed {
    logic [20:0] win;
    logic [36:0] acc;
    logic [15:0] mean;
    logic trip;
    logic done;
  } tprc_mean_st_t;
  tprc_mean_st_t st_reg, st_next;
  logic [20:0] win_end;
  logic [36:0] acc_full;
  logic [15:0] avg;
  assign win_end = 21'((21'h1 << (5'(mean_window_len) + 5'(`TPRC_WINDOW_BASE))) - 21'h1);
  assign acc_full = st_reg.acc + {21'h0, sample_power};
  assign avg = 16'(acc_full >> (5'(mean_window_len) + 5'(`TPRC_WINDOW_BASE)));
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (!enable) begin
      st_next = '0;
    end else if (st_reg.win == win_end) begin
      st_next.win = '0;
      st_next.acc = '0;
      st_next.mean = avg;
      st_next.trip = avg > mean_level_limit;
      st_next.done = 1'b1;
    end else begin
      st_next.win = st_reg.win + 21'h000001;
      st_next.acc = acc_full;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) st_reg <= '0;
    else st_reg <= st_next;
  end
  assign trip = st_reg.trip;
  assign done = st_reg.done;
  assign mean_power = st_reg.mean;
endmodule : tprc_mean_mon

/* tprc_top.sv */
// Purpose: one transmitter's power trip flags and attenuation ramp-down control
// Assumes: Avalon-MM slave, one sample power value per clock
// Notes: transmitter_select bit 0 addresses this transmitter
// Overview of operation
// - peak overload flag reads 1 after peak trip, sticky per selection.
// - mean overload flag reads 1 after mean trip, sticky per selection.
// - tripping mean power is captured, only on a mean error.
// - latest completed mean power result is reported, 16 bits.
// - mean-to-crest ratio reported, valid with both measurements enabled.
// - clear code 1 clears mean, 2 clears peak, 3 clears both.
// - clears act only when write data bit 8 selects this transmitter, whatever transmitter_select holds.
// - protection flags clear by combined event clear or dedicated clear.
// - ramp source map D7 protection, D6..D2 PLLs, D1..D0 deframers.
// - enable value applies to every masked source on selected transmitters.
// - sticky mode restores attenuation after clear and event deassert.
// - auto-clear mode holds ramp-down only while event asserted.
// - enabled event ramps attenuation down to 40 dB.
// - count peaks above limit per window, reset at end, trip on exceed.
// - mean error when window mean exceeds the mean level limit.
// - three sticky selections: events, mean error, peak error.
`include "tprc_consts.svh"
module tprc_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] sample_power,
  input wire logic [6:0] event_in,
  output logic [7:0] atten_db,
  output logic rampdown_active,
  output logic peak_overload_flag,
  output logic mean_overload_flag
);
  typedef struct packed {
    tprc_pkg::tprc_meas_cfg_t cfg;
    logic [7:0] rampdown_source_select;
    logic [2:0] sticky;
    logic transmitter_select;
    logic crest_flag;
    logic mean_flag;
    logic [6:0] evt_latch;
    logic [15:0] trip_power_latched;
    logic [15:0] ratio;
    logic held;
    logic [7:0] atten;
    logic [7:0] restore;
    logic [31:0] rdata;
    logic ack;
    logic [6:0] ev_s1;
    logic [6:0] ev_s2;
  } tprc_state_t;
  tprc_state_t st_reg, st_next;
  logic crest_trip, mean_trip, mean_done;
  logic [15:0] mean_power_result, peak_power;
  logic wr, rd, sel_clr_mean, sel_clr_crest, evt_clear, prot_src, trigger;
  logic [7:0] active_src;
  logic [31:0] q;

  function automatic logic hit(input logic [5:0] a, input logic [7:0] ofs);
    return {a, 2'b00} == ofs;
  endfunction : hit
  function automatic logic clears_mean(input logic [1:0] code);
    return code == `TPRC_CLR_MEAN || code == `TPRC_CLR_BOTH;
  endfunction : clears_mean
  function automatic logic clears_crest(input logic [1:0] code);
    return code == `TPRC_CLR_CREST || code == `TPRC_CLR_BOTH;
  endfunction : clears_crest

  tprc_crest_mon u_crest (
    .clk(clk),
    .reset_n(reset_n),
    .enable(st_reg.cfg.crest_en),
    .sample_power(sample_power),
    .crest_level_limit(st_reg.cfg.crest_level_limit),
    .crest_count_limit(st_reg.cfg.crest_count_limit),
    .crest_window_len(st_reg.cfg.crest_window_len),
    .trip(crest_trip),
    .peak_power(peak_power)
  );
  tprc_mean_mon u_mean (
    .clk(clk),
    .reset_n(reset_n),
    .enable(st_reg.cfg.mean_en),
    .sample_power(sample_power),
    .mean_level_limit(st_reg.cfg.mean_level_limit),
    .mean_window_len(st_reg.cfg.mean_window_len),
    .trip(mean_trip),
    .done(mean_done),
    .mean_power(mean_power_result)
  );

  assign wr = avs_write && !st_reg.ack;
  assign rd = avs_read && !st_reg.ack;
  // clear decode from the clear register, gated by write data bit 8, not by transmitter_select
  always_comb begin
    logic [1:0] code;
    code = avs_writedata[1:0];
    sel_clr_mean = 1'b0;
    sel_clr_crest = 1'b0;
    evt_clear = 1'b0;
    if (wr && avs_writedata[8]) begin
      if (hit(avs_address, `TPRC_OFS_CLEAR)) begin
        sel_clr_mean = clears_mean(code);
        sel_clr_crest = clears_crest(code);
        evt_clear = avs_writedata[2];
        if (avs_writedata[2]) begin
          sel_clr_mean = 1'b1;
          sel_clr_crest = 1'b1;
        end
      end
    end
  end
  assign prot_src = st_reg.crest_flag | st_reg.mean_flag;
  assign active_src = {prot_src, st_reg.evt_latch} & st_reg.rampdown_source_select;
  assign trigger = |active_src;
  always_comb begin
    q = 32'h0;
    unique case ({avs_address, 2'b00})
      `TPRC_OFS_CTRL: q = {29'h0, st_reg.cfg.ratio_en, st_reg.cfg.mean_en, st_reg.cfg.crest_en};
      `TPRC_OFS_RAMP_EN: q = {24'h0, st_reg.rampdown_source_select};
      `TPRC_OFS_STICKY: q = {29'h0, st_reg.sticky};
      `TPRC_OFS_SEL: q = {31'h0, st_reg.transmitter_select};
      `TPRC_OFS_CREST_CFG: q = {st_reg.cfg.crest_level_limit, st_reg.cfg.crest_count_limit,
                                4'h0, st_reg.cfg.crest_window_len};
      `TPRC_OFS_MEAN_CFG: q = {st_reg.cfg.mean_level_limit, 12'h0, st_reg.cfg.mean_window_len};
      `TPRC_OFS_STATUS: q = {st_reg.atten, 13'h0, st_reg.held, st_reg.evt_latch,
                             |st_reg.evt_latch, st_reg.crest_flag, st_reg.mean_flag};
      `TPRC_OFS_MEAN_POWER: q = {16'h0, mean_power_result};
      `TPRC_OFS_TRIP_POWER: q = {16'h0, st_reg.trip_power_latched};
      `TPRC_OFS_RATIO: q = {16'h0, st_reg.ratio};
      default: q = 32'h0;
    endcase
  end
  always_comb begin
    st_next = st_reg;
    st_next.ack = (avs_read || avs_write) && !st_reg.ack;
    st_next.ev_s1 = event_in;
    st_next.ev_s2 = st_reg.ev_s1;
    if (rd) st_next.rdata = q;
    if (wr) begin
      if (hit(avs_address, `TPRC_OFS_SEL)) st_next.transmitter_select = avs_writedata[0];
      if (st_reg.transmitter_select) begin
        if (hit(avs_address, `TPRC_OFS_CTRL)) begin
          st_next.cfg.crest_en = avs_writedata[0];
          st_next.cfg.mean_en = avs_writedata[1];
          st_next.cfg.ratio_en = avs_writedata[2];
        end
        if (hit(avs_address, `TPRC_OFS_STICKY)) st_next.sticky = avs_writedata[2:0];
        if (hit(avs_address, `TPRC_OFS_CREST_CFG)) begin
          st_next.cfg.crest_level_limit = avs_writedata[31:16];
          st_next.cfg.crest_count_limit = avs_writedata[15:8];
          st_next.cfg.crest_window_len = avs_writedata[3:0];
        end
        if (hit(avs_address, `TPRC_OFS_MEAN_CFG)) begin
          st_next.cfg.mean_level_limit = avs_writedata[31:16];
          st_next.cfg.mean_window_len = avs_writedata[3:0];
        end
      end
      if (hit(avs_address, `TPRC_OFS_RAMP_EN) && avs_writedata[16]) begin
        for (int i = 0; i < 8; i++) begin
          if (avs_writedata[i]) st_next.rampdown_source_select[i] = avs_writedata[8];
        end
      end
    end
    // flag clears first, then sets win
    if (sel_clr_mean) st_next.mean_flag = 1'b0;
    if (sel_clr_crest) st_next.crest_flag = 1'b0;
    if (evt_clear) st_next.evt_latch = '0;
    if (!st_reg.sticky[1]) st_next.mean_flag = 1'b0;
    if (!st_reg.sticky[0]) st_next.crest_flag = 1'b0;
    if (!st_reg.sticky[2]) st_next.evt_latch = '0;
    if (crest_trip) st_next.crest_flag = 1'b1;
    if (mean_trip) st_next.mean_flag = 1'b1;
    st_next.evt_latch = st_next.evt_latch | st_reg.ev_s2;
    if (mean_done && mean_trip) st_next.trip_power_latched = mean_power_result;
    if (st_reg.cfg.ratio_en && st_reg.cfg.crest_en && st_reg.cfg.mean_en && mean_done)
      st_next.ratio = peak_power == 16'h0 ? 16'h0 :
                      16'(({mean_power_result, 16'h0}) / {16'h0, peak_power});
    // ramp-down held while any enabled source stands (sticky via latched flags)
    if (trigger) begin
      if (!st_reg.held) st_next.restore = st_reg.atten;
      st_next.held = 1'b1;
      if (st_reg.atten < `TPRC_ATTEN_MAX_DB)
        st_next.atten = st_reg.atten + `TPRC_ATTEN_STEP;
    end else if (st_reg.held) begin
      st_next.held = 1'b0;
      st_next.atten = st_reg.restore;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
      st_reg.sticky <= `TPRC_STICKY_RST;
      st_reg.transmitter_select <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0;
      avs_waitrequest <= 1'b1;
      atten_db <= 8'h0;
      rampdown_active <= 1'b0;
      peak_overload_flag <= 1'b0;
      mean_overload_flag <= 1'b0;
    end else begin
      avs_readdata <= st_next.rdata;
      avs_waitrequest <= !st_next.ack;
      atten_db <= st_next.atten;
      rampdown_active <= st_next.held;
      peak_overload_flag <= st_next.crest_flag;
      mean_overload_flag <= st_next.mean_flag;
    end
  end

  sequence clear_mean_s;
    wr && hit(avs_address, `TPRC_OFS_CLEAR) && avs_writedata[8] && avs_writedata[1:0] == 2'h1;
  endsequence
  clear_mean_a: assert property (@(posedge clk) disable iff (!reset_n)
    (clear_mean_s and !mean_trip) |=> !st_reg.mean_flag) else $error("mean clear failed");
  set_wins_a: assert property (@(posedge clk) disable iff (!reset_n)
    crest_trip |=> st_reg.crest_flag) else $error("peak trip lost");
  mean_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    mean_trip |=> st_reg.mean_flag) else $error("mean trip lost");
  unsel_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr && !avs_writedata[8] && st_reg.sticky[1] && st_reg.mean_flag |=> st_reg.mean_flag)
    else $error("unselected cleared");
  capture_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(mean_done && mean_trip) |=> $stable(st_reg.trip_power_latched))
    else $error("capture moved");
  ramp_cap_a: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.held |-> st_reg.atten <= `TPRC_ATTEN_MAX_DB || $past(st_reg.held) == 1'b0)
    else $error("atten over limit");
  ramp_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    trigger |=> st_reg.held) else $error("ramp not held");
  release_a: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.held && !trigger |=> !st_reg.held ##0 st_reg.atten == $past(st_reg.restore))
    else $error("restore wrong");
  bus_ack_a: assert property (@(posedge clk) disable iff (!reset_n)
    avs_write && !st_reg.ack |=> !avs_waitrequest) else $error("no ack");
  sequence clear_crest_s;
    wr && hit(avs_address, `TPRC_OFS_CLEAR) && avs_writedata[8]
      && clears_crest(avs_writedata[1:0]);
  endsequence
  sequence event_clear_s;
    wr && hit(avs_address, `TPRC_OFS_CLEAR) && avs_writedata[8] && avs_writedata[2];
  endsequence
  sequence ramp_write_s;
    wr && hit(avs_address, `TPRC_OFS_RAMP_EN) && avs_writedata[16];
  endsequence
  crest_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    (clear_crest_s and !crest_trip) |=> !st_reg.crest_flag)
    else $error("peak clear failed");
  evt_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    (event_clear_s and (st_reg.ev_s2 == 7'h00 && !crest_trip && !mean_trip))
      |=> st_reg.evt_latch == 7'h00 && !st_reg.crest_flag && !st_reg.mean_flag)
    else $error("combined clear failed");
  ramp_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    (ramp_write_s and avs_writedata[8]) |=>
      (st_reg.rampdown_source_select & 8'($past(avs_writedata))) == 8'($past(avs_writedata)))
    else $error("ramp source not enabled");
  ramp_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    (ramp_write_s and !avs_writedata[8]) |=>
      (st_reg.rampdown_source_select & 8'($past(avs_writedata))) == 8'h00)
    else $error("ramp source not disabled");
  ramp_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr && hit(avs_address, `TPRC_OFS_RAMP_EN) && !avs_writedata[16]
      |=> $stable(st_reg.rampdown_source_select)) else $error("unselected ramp write");
  mean_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
    !st_reg.sticky[1] |=> st_reg.mean_flag == $past(mean_trip))
    else $error("mean flag stuck");
  crest_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
    !st_reg.sticky[0] |=> st_reg.crest_flag == $past(crest_trip))
    else $error("peak flag stuck");
  evt_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
    !st_reg.sticky[2] |=> st_reg.evt_latch == $past(st_reg.ev_s2))
    else $error("event stuck");
  crest_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.sticky[0] && st_reg.crest_flag && !sel_clr_crest |=> st_reg.crest_flag)
    else $error("peak flag lost");
  evt_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.sticky[2] && !evt_clear
      |=> (st_reg.evt_latch & $past(st_reg.evt_latch)) == $past(st_reg.evt_latch))
    else $error("event lost");
  atten_step_a: assert property (@(posedge clk) disable iff (!reset_n)
    trigger && st_reg.atten < `TPRC_ATTEN_MAX_DB
      |=> st_reg.atten == 8'($past(st_reg.atten) + `TPRC_ATTEN_STEP))
    else $error("no ramp step");
  capture_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    mean_done && mean_trip |=> st_reg.trip_power_latched == $past(mean_power_result))
    else $error("trip power not captured");
  ratio_freeze_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(st_reg.cfg.ratio_en && st_reg.cfg.crest_en && st_reg.cfg.mean_en)
      |=> $stable(st_reg.ratio)) else $error("ratio moved");
  mean_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    rd && hit(avs_address, `TPRC_OFS_MEAN_POWER)
      |=> !avs_waitrequest && avs_readdata == {16'h0, $past(mean_power_result)})
    else $error("mean read wrong");
  trip_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    rd && hit(avs_address, `TPRC_OFS_TRIP_POWER)
      |=> !avs_waitrequest && avs_readdata == {16'h0, $past(st_reg.trip_power_latched)})
    else $error("trip read wrong");
endmodule : tprc_top

/* tprc_host_model.sv */
// Purpose: control software side of the block, an Avalon-MM master
// Assumes: the answer is waitrequest low, read data valid beside it
// Notes: answer and read data are taken at the rising edge that sees waitrequest low
module tprc_host_model (
  input wire logic clk,
  output logic [5:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end
  // flags are read only after configuration, cleared after the cause is gone, except one peak clear in t_codes written while the level stands
  task automatic access(input logic wr, input logic [7:0] ofs, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
    int n;
    ok = 1'b0;
    q = 32'h0;
    @(posedge clk);
    avs_address <= ofs[7:2];
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= d;
    for (n = 0; n < 50 && !ok; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) begin
        ok = 1'b1;
        q = avs_readdata;
      end
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : access
endmodule : tprc_host_model

/* tb_tprc_top.sv */
// Purpose: self-checking bench for the power trip and ramp-down block
// Assumes: windows of 32 samples (length field 0)
// Notes: sample power is a level or a 0/2000h alternation
`include "tprc_consts.svh"
module tb_tprc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, avs_read, avs_write, avs_waitrequest, alt;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [15:0] sample_power, lvl;
  logic [6:0] event_in;
  logic [7:0] atten_db;
  logic rampdown_active, peak_overload_flag, mean_overload_flag;
  logic [10:0] obs;
  localparam logic [10:0] M_F = 11'h003;
  localparam logic [10:0] M_R = 11'h7FC;
  localparam logic [10:0] RAMPED = 11'h144;
  int mismatches, n_checks;
  assign obs = {atten_db, rampdown_active, peak_overload_flag, mean_overload_flag};
  tprc_top i_dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sample_power(sample_power), .event_in(event_in), .atten_db(atten_db),
    .rampdown_active(rampdown_active), .peak_overload_flag(peak_overload_flag),
    .mean_overload_flag(mean_overload_flag));
  tprc_host_model i_host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) sample_power <= alt ? (~sample_power & 16'h2000) : lvl;
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [7:0] o, input logic [31:0] d);
    logic ok;
    i_host.access(wr, o, d, q, ok);
    check(ok, 1'b1);
    if (ok !== 1'b1) report_and_stop();
  endtask : bus
  task automatic rd_chk(input logic [7:0] o, input logic [31:0] exp);
    bus(1'b0, o, 32'h0);
    check(q, exp);
  endtask : rd_chk
  task automatic wait_obs(input logic [10:0] m, input logic [10:0] v, input int lim);
    for (int n = 0; n < lim && (obs & m) !== v; n++) @(negedge clk);
    check(obs & m, v);
    if ((obs & m) !== v) report_and_stop();
  endtask : wait_obs
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle
  task automatic t_reset();
    check(obs, 11'h000);
    check(avs_waitrequest, 1'b1);
    rd_chk(`TPRC_OFS_STICKY, 32'h7);
    rd_chk(8'hFC, 32'h0);
  endtask : t_reset
  task automatic t_mean();
    bus(1'b1, `TPRC_OFS_CREST_CFG, 32'hFFFF0000);
    bus(1'b1, `TPRC_OFS_MEAN_CFG, 32'h0FFF0000);
    bus(1'b1, `TPRC_OFS_CTRL, 32'h7);
    alt = 1'b1;
    wait_obs(M_F, 11'h001, 200);
    settle(70);
    rd_chk(`TPRC_OFS_MEAN_POWER, 32'h1000);
    rd_chk(`TPRC_OFS_RATIO, 32'h8000);
    alt = 1'b0;
    lvl = 16'h0000;
    settle(70);
    rd_chk(`TPRC_OFS_MEAN_POWER, 32'h0);
    rd_chk(`TPRC_OFS_TRIP_POWER, 32'h1000);
    check(obs & M_F, 11'h001);
    bus(1'b1, `TPRC_OFS_CLEAR, 32'h101);
    wait_obs(M_F, 11'h000, 10);
  endtask : t_mean
  task automatic t_codes();
    bus(1'b1, `TPRC_OFS_CREST_CFG, 32'h10000200);
    bus(1'b1, `TPRC_OFS_CTRL, 32'h3);
    for (int c = 1; c <= 3; c++) begin
      lvl = 16'h2000;
      wait_obs(M_F, 11'h003, 200);
      lvl = 16'h0000;
      settle(70);
      check(obs & M_F, 11'h003);
      bus(1'b1, `TPRC_OFS_CLEAR, 32'(c));
      settle(3);
      check(obs & M_F, 11'h003);
      bus(1'b1, `TPRC_OFS_CLEAR, 32'h100 | 32'(c));
      settle(3);
      check(obs & M_F, 11'(~c & 3));
      bus(1'b1, `TPRC_OFS_CLEAR, 32'h103);
    end
    lvl = 16'h2000;
    wait_obs(M_F, 11'h003, 200);
    bus(1'b1, `TPRC_OFS_CLEAR, 32'h102);
    settle(3);
    check(peak_overload_flag, 1'b1);
    lvl = 16'h0000;
    settle(70);
    bus(1'b1, `TPRC_OFS_CLEAR, 32'h103);
  endtask : t_codes
  // source masks below are never empty
  task automatic t_ramp();
    bus(1'b1, `TPRC_OFS_RAMP_EN, 32'h10180);
    lvl = 16'h2000;
    wait_obs(M_R, RAMPED, 300);
    lvl = 16'h0000;
    settle(70);
    check(obs & M_R, RAMPED);
    bus(1'b1, `TPRC_OFS_CLEAR, 32'h104);
    wait_obs(11'h7FF, 11'h000, 60);
    bus(1'b1, `TPRC_OFS_RAMP_EN, 32'h10080);
  endtask : t_ramp
  task automatic t_events();
    bus(1'b1, `TPRC_OFS_RAMP_EN, 32'h1017F);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk) event_in <= 7'(1 << i);
      wait_obs(M_R, RAMPED, 100);
      bus(1'b0, `TPRC_OFS_STATUS, 32'h0);
      check(q[3 + i], 1'b1);
      @(posedge clk) event_in <= 7'h00;
      settle(10);
      check(obs & M_R, RAMPED);
      bus(1'b1, `TPRC_OFS_CLEAR, 32'h104);
      wait_obs(M_R, 11'h000, 60);
    end
  endtask : t_events
  task automatic t_auto();
    bus(1'b1, `TPRC_OFS_STICKY, 32'h0);
    @(posedge clk) event_in <= 7'h10;
    wait_obs(M_R, RAMPED, 100);
    @(posedge clk) event_in <= 7'h00;
    wait_obs(M_R, 11'h000, 60);
    bus(1'b1, `TPRC_OFS_RAMP_EN, 32'h1007F);
    bus(1'b1, `TPRC_OFS_RAMP_EN, 32'h00110);
    @(posedge clk) event_in <= 7'h10;
    settle(60);
    check(obs & M_R, 11'h000);
    @(posedge clk) event_in <= 7'h00;
  endtask : t_auto
  initial begin
    reset_n = 1'b0;
    event_in = 7'h00;
    sample_power = 16'h0000;
    lvl = 16'h0000;
    alt = 1'b0;
    mismatches = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    t_reset();
    t_mean();
    t_codes();
    t_ramp();
    t_events();
    t_auto();
    report_and_stop();
  end
endmodule : tb_tprc_top
